// ### rtl/ldsfc_pkg.sv
package ldsfc_pkg;
	// string count and clock
	localparam int NUM_STRINGS = 4;
	localparam int CLK_MHZ = 100;
	// fault must persist this long before it counts as verified
	localparam int CONFIRM_US = 10;
	localparam int CONFIRM_CYCLES = CONFIRM_US * CLK_MHZ;
	localparam int CONFIRM_W = $clog2(CONFIRM_CYCLES + 1);
	localparam logic [CONFIRM_W-1:0] CONFIRM_FULL = CONFIRM_W'(CONFIRM_CYCLES);
	localparam logic [CONFIRM_W-1:0] CONFIRM_LAST = CONFIRM_W'(CONFIRM_CYCLES - 1);
	localparam logic [CONFIRM_W-1:0] CONFIRM_STEP = CONFIRM_W'(1);
	// shared-input period measurement
	localparam int PERIOD_W = 16;
	localparam logic [PERIOD_W-1:0] PERIOD_MAX = 16'hffff;
	localparam logic [PERIOD_W-1:0] PERIOD_STEP = 16'h0001;
	localparam int PHASE_SHIFT = 2;
	// layout of the synchronised pin vector
	localparam int SYNC_W = 14;
	localparam int SYNC_EN = 0;
	localparam int SYNC_DIM_LO = 1;
	localparam int SYNC_DRN_LO = 5;
	localparam int SYNC_SRC_LO = 9;
	localparam int SYNC_OT = 13;
	// peak current setting
	localparam int CURRENT_W = 8;
	localparam logic [CURRENT_W-1:0] CURRENT_DEFAULT = 8'hff;
	// shared-input phase lock
	typedef enum logic [1:0] {
		LDSFC_LOCK_IDLE,
		LDSFC_LOCK_MEASURE,
		LDSFC_LOCK_RUN
	} ldsfc_lock_t;
endpackage

// ### rtl/ldsfc_sync.sv
module ldsfc_sync #(
	parameter int WIDTH = ldsfc_pkg::SYNC_W
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// pins in, filtered levels out
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level
);
	import ldsfc_pkg::*;

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= pin;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// a change counts only once stages two and three agree
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			level <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2[i] == stage3[i]) begin
					level[i] <= stage3[i];
				end
			end
		end
	end
endmodule // ldsfc_sync

// ### rtl/ldsfc_confirm.sv
module ldsfc_confirm (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// condition and its verified event
	input wire logic clear,
	input wire logic cond,
	output logic hit
);
	import ldsfc_pkg::*;

	logic [CONFIRM_W-1:0] count;

	////////////////////////////////////////////////////////////////////////
	// any gap in the condition restarts verification
	always_ff @(posedge ref_clk) begin
		if (!rst_b || clear || !cond) begin
			count <= '0;
		end else if (count != CONFIRM_FULL) begin
			count <= count + CONFIRM_STEP;
		end
	end

	// one pulse per verified episode
	always_ff @(posedge ref_clk) begin
		if (!rst_b || clear) begin
			hit <= 1'b0;
		end else begin
			hit <= cond && (count == CONFIRM_LAST);
		end
	end
endmodule // ldsfc_confirm

// ### rtl/ldsfc_top.sv
// Behaviour
// - enable high runs; low turns strings off
// - enable low clears flag, restores defaults
// - flag asserts only after verified fault
// - fault register read clears the flag
// - open or short string: drive off, flag
// - detect open, short and over-temperature
// - per-string mode: each follows own input
// - shared mode: one input, staggered phases
// - eight-bit setting scales current reference
// - runs stand-alone; host access optional
module ldsfc_top (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// enable and variant select
	input wire logic enable,
	input wire logic shared_dim_mode,
	// dimming inputs
	input wire logic dim_in_0,
	input wire logic dim_in_1,
	input wire logic dim_in_2,
	input wire logic dim_in_3,
	// string sense comparators
	input wire logic [ldsfc_pkg::NUM_STRINGS-1:0] string_drain_sense,
	input wire logic [ldsfc_pkg::NUM_STRINGS-1:0] string_source_sense,
	input wire logic over_temp_sense,
	// optional host access
	input wire logic setting_wr,
	input wire logic [ldsfc_pkg::CURRENT_W-1:0] setting_data,
	input wire logic fault_read_strobe,
	// string drive and current reference
	output logic [ldsfc_pkg::NUM_STRINGS-1:0] string_gate_drive,
	output logic [ldsfc_pkg::CURRENT_W-1:0] current_ref,
	// fault flag, open drain
	output logic fault_flag_n_out,
	output logic fault_flag_n_oe,
	// status
	output logic [ldsfc_pkg::NUM_STRINGS-1:0] open_fault,
	output logic [ldsfc_pkg::NUM_STRINGS-1:0] short_fault,
	output logic over_temp_fault,
	output logic device_on
);
	import ldsfc_pkg::*;

	logic [SYNC_W-1:0] sync_level;
	logic en_s;
	logic [NUM_STRINGS-1:0] dim_s;
	logic [NUM_STRINGS-1:0] drain_s;
	logic [NUM_STRINGS-1:0] source_s;
	logic ot_s;
	logic clear_all;
	logic dim_prev;
	logic dim_rise;
	logic dim_fall;
	logic cnt_sat;
	logic [PERIOD_W-1:0] phase_cnt;
	logic [PERIOD_W-1:0] period;
	logic [PERIOD_W-1:0] high_time;
	ldsfc_lock_t lock_state;
	logic [NUM_STRINGS-1:0] staggered;
	logic [NUM_STRINGS-1:0] next_gate;
	logic [NUM_STRINGS-1:0] string_off;
	logic [NUM_STRINGS-1:0] open_hit;
	logic [NUM_STRINGS-1:0] short_hit;
	logic ot_hit;
	logic any_hit;
	logic [CURRENT_W-1:0] current_setting;

	// drive is on at this position within the period
	function automatic logic stagger_on(input int k, input logic [PERIOD_W-1:0] cnt,
		input logic [PERIOD_W-1:0] per, input logic [PERIOD_W-1:0] hi);
		logic [PERIOD_W+1:0] offset;
		logic [PERIOD_W+1:0] pos;
		offset = ((PERIOD_W + 2)'(k) * {2'b00, per}) >> PHASE_SHIFT;
		if ({2'b00, cnt} >= offset) begin
			pos = {2'b00, cnt} - offset;
		end else begin
			pos = {2'b00, cnt} + {2'b00, per} - offset;
		end
		return pos < {2'b00, hi};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	ldsfc_sync #(
		.WIDTH(SYNC_W)
	) u_sync (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.pin({over_temp_sense, string_source_sense, string_drain_sense,
			dim_in_3, dim_in_2, dim_in_1, dim_in_0, enable}),
		.level(sync_level)
	);

	assign en_s = sync_level[SYNC_EN];
	assign dim_s = sync_level[SYNC_DIM_LO +: NUM_STRINGS];
	assign drain_s = sync_level[SYNC_DRN_LO +: NUM_STRINGS];
	assign source_s = sync_level[SYNC_SRC_LO +: NUM_STRINGS];
	assign ot_s = sync_level[SYNC_OT];
	// enable low acts as a full soft reset of control state
	assign clear_all = !en_s;

	////////////////////////////////////////////////////////////////////////
	// shared-input period and high-time measurement
	assign dim_rise = dim_s[0] && !dim_prev;
	assign dim_fall = !dim_s[0] && dim_prev;
	assign cnt_sat = (phase_cnt == PERIOD_MAX);

	always_ff @(posedge ref_clk) begin
		if (!rst_b || clear_all) begin
			dim_prev <= 1'b0;
		end else begin
			dim_prev <= dim_s[0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b || clear_all) begin
			phase_cnt <= '0;
		end else if (dim_rise) begin
			phase_cnt <= '0;
		end else if (!cnt_sat) begin
			phase_cnt <= phase_cnt + PERIOD_STEP;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b || clear_all) begin
			period <= '0;
			high_time <= '0;
		end else begin
			if (dim_rise && lock_state != LDSFC_LOCK_IDLE) begin
				period <= phase_cnt + PERIOD_STEP;
			end
			if (dim_fall) begin
				high_time <= phase_cnt + PERIOD_STEP;
			end
		end
	end

	// a stuck input drops the lock so strings follow it directly
	always_ff @(posedge ref_clk) begin
		if (!rst_b || clear_all) begin
			lock_state <= LDSFC_LOCK_IDLE;
		end else begin
			unique case (lock_state)
				LDSFC_LOCK_IDLE: begin
					if (dim_rise) begin
						lock_state <= LDSFC_LOCK_MEASURE;
					end
				end
				LDSFC_LOCK_MEASURE: begin
					if (cnt_sat) begin
						lock_state <= LDSFC_LOCK_IDLE;
					end else if (dim_rise) begin
						lock_state <= LDSFC_LOCK_RUN;
					end
				end
				LDSFC_LOCK_RUN: begin
					if (cnt_sat) begin
						lock_state <= LDSFC_LOCK_IDLE;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// drive selection; in per-string mode unused inputs tied low keep strings dark
	always_comb begin
		staggered = '0;
		next_gate = '0;
		for (int i = 0; i < NUM_STRINGS; i++) begin
			if (i == 0 || lock_state != LDSFC_LOCK_RUN) begin
				staggered[i] = dim_s[0];
			end else begin
				staggered[i] = stagger_on(i, phase_cnt, period, high_time);
			end
			if (shared_dim_mode) begin
				next_gate[i] = staggered[i];
			end else begin
				next_gate[i] = dim_s[i];
			end
			next_gate[i] = next_gate[i] && en_s && !string_off[i];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			string_gate_drive <= '0;
		end else begin
			string_gate_drive <= next_gate;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// fault verification: open = on but no current, short = excess headroom
	genvar g;
	generate
		for (g = 0; g < NUM_STRINGS; g++) begin : g_string
			ldsfc_confirm u_open (
				.ref_clk(ref_clk),
				.rst_b(rst_b),
				.clear(clear_all),
				.cond(string_gate_drive[g] && !source_s[g]),
				.hit(open_hit[g])
			);
			ldsfc_confirm u_short (
				.ref_clk(ref_clk),
				.rst_b(rst_b),
				.clear(clear_all),
				.cond(string_gate_drive[g] && drain_s[g]),
				.hit(short_hit[g])
			);
		end
	endgenerate

	ldsfc_confirm u_ot (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.clear(clear_all),
		.cond(ot_s),
		.hit(ot_hit)
	);

	assign any_hit = (|open_hit) || (|short_hit) || ot_hit;
	assign string_off = open_fault | short_fault;

	// status stays latched until an enable cycle, reads do not clear it
	always_ff @(posedge ref_clk) begin
		if (!rst_b || clear_all) begin
			open_fault <= '0;
			short_fault <= '0;
			over_temp_fault <= 1'b0;
		end else begin
			open_fault <= open_fault | open_hit;
			short_fault <= short_fault | short_hit;
			over_temp_fault <= over_temp_fault || ot_hit;
		end
	end

	// a new fault in the read cycle wins over the clear
	always_ff @(posedge ref_clk) begin
		if (!rst_b || clear_all) begin
			fault_flag_n_oe <= 1'b0;
		end else if (any_hit) begin
			fault_flag_n_oe <= 1'b1;
		end else if (fault_read_strobe) begin
			fault_flag_n_oe <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			fault_flag_n_out <= 1'b0;
			device_on <= 1'b0;
		end else begin
			fault_flag_n_out <= 1'b0;
			device_on <= en_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// peak current: default is full scale so no host is needed
	always_ff @(posedge ref_clk) begin
		if (!rst_b || clear_all) begin
			current_setting <= CURRENT_DEFAULT;
		end else if (setting_wr) begin
			current_setting <= setting_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			current_ref <= CURRENT_DEFAULT;
		end else if (!en_s) begin
			current_ref <= CURRENT_DEFAULT;
		end else if (setting_wr) begin
			current_ref <= setting_data;
		end else begin
			current_ref <= current_setting;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	AST_OFF_WHEN_DISABLED: assert property (!en_s |=> string_gate_drive == '0)
		else $error("string drive while disabled");
	AST_DEFAULTS_RESTORED: assert property (!en_s |=> !fault_flag_n_oe && open_fault == '0
		&& short_fault == '0 && current_ref == CURRENT_DEFAULT)
		else $error("defaults not restored by disable");
	AST_FLAG_NEEDS_VERIFY: assert property ($rose(fault_flag_n_oe) |-> $past(any_hit))
		else $error("fault flag without verified fault");
	AST_READ_CLEARS_FLAG: assert property (en_s && fault_read_strobe && !any_hit
		|=> !fault_flag_n_oe)
		else $error("fault read did not clear flag");
	AST_FAULTED_STRING_OFF: assert property (|(open_fault | short_fault)
		|=> (string_gate_drive & $past(open_fault | short_fault)) == '0)
		else $error("faulted string still driven");
	AST_OVER_TEMP_LATCH: assert property (en_s && ot_hit |=> over_temp_fault
		&& fault_flag_n_oe)
		else $error("over-temperature not latched");
	AST_PER_STRING_FOLLOW: assert property (en_s && !shared_dim_mode && string_off == '0
		|=> string_gate_drive == $past(dim_s))
		else $error("string does not follow its input");
	AST_SHARED_STRING0: assert property (en_s && shared_dim_mode && !string_off[0]
		|=> string_gate_drive[0] == $past(dim_s[0]))
		else $error("shared mode string zero mismatch");
	AST_SETTING_APPLIED: assert property (en_s && setting_wr ##1 en_s
		|-> current_ref == $past(setting_data))
		else $error("current setting not applied");
	AST_LOCKOUT_HOLDS: assert property (en_s && string_off[2] ##1 en_s
		|-> string_off[2] [*2])
		else $error("string lockout released early");
endmodule // ldsfc_top

// ### testbench/ldsfc_string_model.sv
module ldsfc_string_model (
	// gate drive from the block
	input wire logic [ldsfc_pkg::NUM_STRINGS-1:0] string_gate_drive,
	// faults injected by the bench
	input wire logic [ldsfc_pkg::NUM_STRINGS-1:0] open_mask,
	input wire logic [ldsfc_pkg::NUM_STRINGS-1:0] short_mask,
	// sense comparators back to the block
	output logic [ldsfc_pkg::NUM_STRINGS-1:0] string_drain_sense,
	output logic [ldsfc_pkg::NUM_STRINGS-1:0] string_source_sense
);
	timeunit 1ns;
	timeprecision 1ns;
	import ldsfc_pkg::*;
	// current only flows through a driven, intact string
	assign string_source_sense = string_gate_drive & ~open_mask;
	// shorted leds leave too much drain headroom, seen only while conducting
	assign string_drain_sense = string_gate_drive & short_mask;
endmodule // ldsfc_string_model

// ### testbench/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import ldsfc_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic enable = 1'b0;
	logic shared_dim_mode = 1'b0;
	logic [3:0] dim = 4'h0;
	logic [3:0] open_mask = 4'h0;
	logic [3:0] short_mask = 4'h0;
	logic over_temp_sense = 1'b0;
	logic setting_wr = 1'b0;
	logic [7:0] setting_data = 8'h00;
	logic fault_read_strobe = 1'b0;
	logic [3:0] string_drain_sense, string_source_sense, string_gate_drive;
	logic [3:0] open_fault, short_fault;
	logic [7:0] current_ref;
	logic fault_flag_n_out, fault_flag_n_oe, over_temp_fault, device_on, fault_flag_n;
	int error_cnt = 0;
	int samples_checked = 0;
	int i, hi_seen, skew_seen;
	always #5 ref_clk = ~ref_clk;
	// open drain with board pull-up
	assign fault_flag_n = fault_flag_n_oe ? fault_flag_n_out : 1'b1;
	ldsfc_top ldsfc_top_i (
		.ref_clk(ref_clk), .rst_b(rst_b), .enable(enable), .shared_dim_mode(shared_dim_mode),
		.dim_in_0(dim[0]), .dim_in_1(dim[1]), .dim_in_2(dim[2]), .dim_in_3(dim[3]),
		.string_drain_sense(string_drain_sense), .string_source_sense(string_source_sense),
		.over_temp_sense(over_temp_sense), .setting_wr(setting_wr),
		.setting_data(setting_data), .fault_read_strobe(fault_read_strobe),
		.string_gate_drive(string_gate_drive), .current_ref(current_ref),
		.fault_flag_n_out(fault_flag_n_out), .fault_flag_n_oe(fault_flag_n_oe),
		.open_fault(open_fault), .short_fault(short_fault),
		.over_temp_fault(over_temp_fault), .device_on(device_on)
	);
	ldsfc_string_model ldsfc_string_model_i (
		.string_gate_drive(string_gate_drive), .open_mask(open_mask), .short_mask(short_mask),
		.string_drain_sense(string_drain_sense), .string_source_sense(string_source_sense)
	);
	////////////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic pulse_write(input logic [7:0] code);
		setting_data = code;
		setting_wr = 1'b1;
		tick(1);
		setting_wr = 1'b0;
		// let an edge pass so a following call does not retoggle the strobe
		tick(1);
	endtask
	task automatic pulse_read();
		fault_read_strobe = 1'b1;
		tick(1);
		fault_read_strobe = 1'b0;
		tick(1);
	endtask
	// bounded wait, enough for the 1000-cycle confirmation plus sync
	task automatic wait_flag(input logic lvl);
		for (i = 0; i < 1200 && fault_flag_n !== lvl; i++) tick(1);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// whole run is about 3300 cycles
	initial begin
		#(40000 * 10);
		error_cnt++;
		wrap_up();
	end
	initial begin
		tick(20);
		rst_b = 1'b1;
		tick(2);
		chk("reset ref", current_ref, CURRENT_DEFAULT);
		chk("reset gate", {4'h0, string_gate_drive}, 8'h00);
		// unused inputs held low keep strings dark
		dim = 4'h0;
		enable = 1'b1;
		for (i = 0; i < 10 && device_on !== 1'b1; i++) tick(1);
		chk("device on", {7'h0, device_on}, 8'h01);
		dim = 4'h2;
		tick(6);
		chk("gate one", {4'h0, string_gate_drive}, 8'h02);
		dim = 4'h5;
		tick(6);
		chk("gate pattern", {4'h0, string_gate_drive}, 8'h05);
		pulse_write(8'h5a);
		chk("ref write", current_ref, 8'h5a);
		pulse_write(8'h00);
		chk("ref zero", current_ref, 8'h00);
		// open string 2 while lit: flag waits for the full confirmation
		open_mask = 4'h4;
		dim = 4'h4;
		tick(600);
		chk("flag early", {7'h0, fault_flag_n}, 8'h01);
		wait_flag(1'b0);
		chk("flag open", {7'h0, fault_flag_n}, 8'h00);
		chk("open stat", {4'h0, open_fault}, 8'h04);
		tick(3);
		chk("gate off", {4'h0, string_gate_drive}, 8'h00);
		dim = 4'h0;
		tick(5);
		dim = 4'h4;
		tick(8);
		chk("locked off", {4'h0, string_gate_drive}, 8'h00);
		pulse_read();
		chk("read clear", {7'h0, fault_flag_n}, 8'h01);
		chk("stat kept", {4'h0, open_fault}, 8'h04);
		// shorted leds on string 3
		short_mask = 4'h8;
		dim = 4'hc;
		wait_flag(1'b0);
		chk("short stat", {4'h0, short_fault}, 8'h08);
		tick(3);
		chk("short off", {4'h0, string_gate_drive}, 8'h00);
		pulse_read();
		over_temp_sense = 1'b1;
		wait_flag(1'b0);
		chk("temp stat", {7'h0, over_temp_fault}, 8'h01);
		over_temp_sense = 1'b0;
		// enable low: everything back to power-up state
		enable = 1'b0;
		tick(8);
		chk("off gate", {4'h0, string_gate_drive}, 8'h00);
		chk("off flag", {7'h0, fault_flag_n}, 8'h01);
		chk("off ref", current_ref, CURRENT_DEFAULT);
		chk("off stat", {open_fault, short_fault}, 8'h00);
		chk("off temp", {7'h0, over_temp_fault}, 8'h00);
		open_mask = 4'h0;
		short_mask = 4'h0;
		dim = 4'h0;
		shared_dim_mode = 1'b1;
		enable = 1'b1;
		tick(10);
		// shared input, 40-cycle period; string 1 must lag string 0
		hi_seen = 0;
		skew_seen = 0;
		repeat (12) begin
			dim[0] = ~dim[0];
			repeat (20) begin
				tick(1);
				if (string_gate_drive[1] === 1'b1) hi_seen++;
				if (string_gate_drive[1] !== string_gate_drive[0]) skew_seen++;
			end
		end
		chk("shared lit", {7'h0, hi_seen > 0}, 8'h01);
		chk("shared skew", {7'h0, skew_seen > 0}, 8'h01);
		chk("no fault", {7'h0, fault_flag_n}, 8'h01);
		wrap_up();
	end
endmodule // testbench
